// >>> design/err_classifier.sv
// Maps an error code to exactly one error class
`default_nettype none
`include "err_queue_cfg.svh"
module err_classifier (
    input  wire logic signed [15:0]        code,
    output err_queue_pkg::err_class_t      errClass
);
    function automatic err_queue_pkg::err_class_t classify(input logic signed [15:0] c);
        // First match wins, so a code lands in one class only
        if (c >= -16'sd499 && c <= -16'sd400)
            return err_queue_pkg::CLS_QUERY;
        else if ((c >= -16'sd399 && c <= -16'sd300) || (c >= 16'sd201 && c <= 16'sd703)
                 || (c >= 16'sd800 && c <= 16'sd810))
            return err_queue_pkg::CLS_DEVICE;
        else if (c >= -16'sd299 && c <= -16'sd200)
            return err_queue_pkg::CLS_EXEC;
        else if (c >= -16'sd199 && c <= -16'sd100)
            return err_queue_pkg::CLS_CMD;
        else
            return err_queue_pkg::CLS_NONE;
    endfunction

    always_comb begin
        errClass = classify(code);
    end
endmodule
`default_nettype wire

// >>> design/err_entry_mem.sv
// Entry storage for the error queue, registered read data
`default_nettype none
`include "err_queue_cfg.svh"
module err_entry_mem #(
    parameter int DEPTH = `EQ_DEPTH,
    parameter int AW    = 5
) (
    input  wire logic                   clk_sys,
    input  wire logic                   wrEn,
    input  wire logic [AW-1:0]          wrAddr,
    input  wire err_queue_pkg::err_entry_t wrData,
    input  wire logic [AW-1:0]          rdAddr,
    output var  err_queue_pkg::err_entry_t rdData
);
    err_queue_pkg::err_entry_t mem [DEPTH];

    // No reset: contents are only read once the pointers say valid
    always_ff @(posedge clk_sys) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// >>> design/err_queue_cfg.svh
// Constants for the remote error queue and event status block
`ifndef ERR_QUEUE_CFG_SVH
`define ERR_QUEUE_CFG_SVH

`define EQ_DEPTH          30
`define EQ_CODE_W         16
`define EQ_DESC_W         8
`define EQ_CODE_NOERR     16'sh0000
`define EQ_CODE_OVERFLOW  -16'sd350
`define EQ_DESC_NOERR     8'h00
`define EQ_DESC_OVERFLOW  8'h01

// Register offsets of the plain register port
`define EQ_ADDR_W         4
`define EQ_REG_POP        4'h0
`define EQ_REG_DESC       4'h1
`define EQ_REG_COUNT      4'h2
`define EQ_REG_CLEAR      4'h3
`define EQ_REG_ESR        4'h4
`define EQ_REG_IRQ_STAT   4'h5
`define EQ_REG_IRQ_MASK   4'h6
`define EQ_REG_PANEL      4'h7

// Event status register bit positions
`define ESR_QUERY_BIT     2
`define ESR_DEVICE_BIT    3
`define ESR_EXEC_BIT      4
`define ESR_CMD_BIT       5

// Interrupt status bit positions
`define IRQ_ERR_BIT       0
`define IRQ_OVF_BIT       1
`define IRQ_W             2

`endif

// >>> design/err_queue_pkg.sv
// Types shared by the error queue files
`default_nettype none
package err_queue_pkg;
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_QUERY,
        CLS_DEVICE,
        CLS_EXEC,
        CLS_CMD
    } err_class_t;

    typedef struct packed {
        logic signed [15:0] code;
        logic [7:0]         desc;
    } err_entry_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage
`default_nettype wire

// >>> design/error_queue_event_status.sv
// Remote error queue with event status classes and interrupt
//
// Our own choices: the strobed register port and the placing of the registers.
`default_nettype none
`include "err_queue_cfg.svh"
module error_queue_event_status #(
    parameter int DEPTH    = `EQ_DEPTH,
    parameter int PERSIST_W = 4
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    // Error source from the device's parser and execution logic
    input  wire logic                   errValid,
    input  wire logic signed [15:0]     errCode,
    input  wire logic [7:0]             errDesc,
    // Device conditions that must be re-reported while they persist
    input  wire logic [PERSIST_W-1:0]   persistCond,
    input  wire logic [PERSIST_W*16-1:0] persistCode,
    // Protocol events raised elsewhere in the device
    input  wire logic                   outputQueueEmptyRead,
    input  wire logic                   outputQueueLost,
    input  wire logic                   paramOutOfRange,
    input  wire logic                   execStateConflict,
    input  wire logic                   headerUnknown,
    // Register port
    input  wire logic [3:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic [31:0]                 regRdata,
    // Front panel side
    output logic                        panelErrValid,
    output err_queue_pkg::err_entry_t   panelErr,
    output logic                        panelIndicator,
    output logic                        irq
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [AW-1:0]         wrPtr;
        logic [AW-1:0]         rdPtr;
        logic [AW:0]           count;
        logic [7:0]            esr;
        logic [`IRQ_W-1:0]     irqStat;
        logic [`IRQ_W-1:0]     irqMask;
        logic [PERSIST_W-1:0]  persistPend;
        logic                  bypValid;
        err_queue_pkg::err_entry_t bypEntry;
        logic [31:0]           rdata;
        logic                  panelValid;
        err_queue_pkg::err_entry_t panelErr;
        logic                  panelInd;
        logic                  irq;
        err_queue_pkg::err_entry_t lastEntry;
    } state_t;

    state_t stateReg;
    state_t stateNext;

    // Pick one pending event per cycle: direct errors first
    err_queue_pkg::err_entry_t inEntry;
    logic                      inValid;
    logic [PERSIST_W-1:0]      persistTake;
    err_queue_pkg::err_entry_t memWrData;
    err_queue_pkg::err_entry_t headEntry;
    logic [AW-1:0]             rdAddrNext;
    logic [`IRQ_W-1:0]         irqSet;
    logic [`IRQ_W-1:0]         irqClr;

    err_queue_pkg::err_class_t inClass;
    err_queue_pkg::err_entry_t memRd;
    logic                      memWr;
    logic [AW-1:0]             memWrAddr;
    logic                      rdHit;
    logic                      clrHit;

    err_classifier u_classifier (
        .code     (memWrData.code),
        .errClass (inClass)
    );

    err_entry_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_sys (clk_sys),
        .wrEn    (memWr),
        .wrAddr  (memWrAddr),
        .wrData  (memWrData),
        .rdAddr  (rdAddrNext),
        .rdData  (memRd)
    );

    function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
        return (p == LAST) ? '0 : p + 1'b1;
    endfunction

    function automatic logic [AW-1:0] ptrDec(input logic [AW-1:0] p);
        return (p == '0) ? LAST : p - 1'b1;
    endfunction

    assign rdHit  = regRd && regAddr == `EQ_REG_POP;
    assign clrHit = regWr && regAddr == `EQ_REG_CLEAR;

    // Memory reads ahead at the next head, so the popped code can leave a flop
    assign rdAddrNext = stateNext.rdPtr;
    // A write into the head slot at the same edge is not yet in the read data
    assign headEntry  = stateReg.bypValid ? stateReg.bypEntry : memRd;

    always_comb begin
        inEntry     = '0;
        inValid     = 1'b0;
        persistTake = '0;
        if (errValid) begin
            inEntry = '{code: errCode, desc: errDesc};
            inValid = 1'b1;
        end else if (outputQueueEmptyRead || outputQueueLost) begin
            inEntry = '{code: -16'sd410, desc: 8'h10};
            inValid = 1'b1;
        end else if (paramOutOfRange || execStateConflict) begin
            inEntry = '{code: -16'sd222, desc: 8'h20};
            inValid = 1'b1;
        end else if (headerUnknown) begin
            inEntry = '{code: -16'sd113, desc: 8'h30};
            inValid = 1'b1;
        end else begin
            for (int i = 0; i < PERSIST_W; i++) begin
                if (!inValid && stateReg.persistPend[i]) begin
                    inEntry     = '{code: persistCode[i*16 +: 16], desc: 8'h40};
                    inValid     = 1'b1;
                    persistTake = PERSIST_W'(1) << i;
                end
            end
        end
    end

    // Full queue: newest slot is overwritten rather than pushed
    always_comb begin
        memWr     = 1'b0;
        memWrAddr = stateReg.wrPtr;
        memWrData = inEntry;
        if (inValid && !clrHit) begin
            memWr = 1'b1;
            if (stateReg.count == (AW+1)'(DEPTH)) begin
                memWrAddr = ptrDec(stateReg.wrPtr);
                memWrData = '{code: `EQ_CODE_OVERFLOW, desc: `EQ_DESC_OVERFLOW};
            end
        end
    end

    always_comb begin
        stateNext        = stateReg;
        irqSet           = '0;
        irqClr           = '0;
        stateNext.persistPend = stateReg.persistPend & ~persistTake;
        if (inValid && !clrHit) begin
            if (stateReg.count == (AW+1)'(DEPTH)) begin
                irqSet[`IRQ_OVF_BIT] = 1'b1;
            end else begin
                stateNext.wrPtr = ptrInc(stateReg.wrPtr);
                stateNext.count = stateReg.count + 1'b1;
            end
            unique case (inClass)
                err_queue_pkg::CLS_QUERY:  stateNext.esr[`ESR_QUERY_BIT]  = 1'b1;
                err_queue_pkg::CLS_DEVICE: stateNext.esr[`ESR_DEVICE_BIT] = 1'b1;
                err_queue_pkg::CLS_EXEC:   stateNext.esr[`ESR_EXEC_BIT]   = 1'b1;
                err_queue_pkg::CLS_CMD:    stateNext.esr[`ESR_CMD_BIT]    = 1'b1;
                err_queue_pkg::CLS_NONE:   ;
            endcase
            irqSet[`IRQ_ERR_BIT] = 1'b1;
            stateNext.panelInd = 1'b1;
        end
        // Panel queue gets every error; it is drained elsewhere
        stateNext.panelValid = inValid;
        stateNext.panelErr   = inEntry;
        if (rdHit) begin
            stateNext.panelInd = 1'b0;
            if (stateReg.count != '0) begin
                stateNext.lastEntry = headEntry;
                // A simultaneous push only adds; the pop still takes the oldest
                stateNext.rdPtr     = ptrInc(stateReg.rdPtr);
                stateNext.count     = stateNext.count - 1'b1;
            end else begin
                stateNext.lastEntry = '{code: `EQ_CODE_NOERR, desc: `EQ_DESC_NOERR};
            end
        end
        if (clrHit) begin
            stateNext.wrPtr  = '0;
            stateNext.rdPtr  = '0;
            stateNext.count  = '0;
            stateNext.esr    = '0;
            stateNext.panelInd = 1'b0;
            stateNext.persistPend = persistCond;
        end
        stateNext.bypValid = memWr && memWrAddr == stateNext.rdPtr;
        stateNext.bypEntry = memWrData;
        if (regWr) begin
            unique case (regAddr)
                `EQ_REG_IRQ_STAT: irqClr = regWdata[`IRQ_W-1:0];
                `EQ_REG_IRQ_MASK: stateNext.irqMask = regWdata[`IRQ_W-1:0];
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle, so no event is lost
        stateNext.irqStat = (stateReg.irqStat & ~irqClr) | irqSet;
        stateNext.rdata = '0;
        if (regRd) begin
            unique case (regAddr)
                `EQ_REG_POP:      stateNext.rdata = (stateReg.count != '0)
                    ? {{16{headEntry.code[15]}}, headEntry.code}
                    : {16'h0000, `EQ_CODE_NOERR};
                `EQ_REG_DESC:     stateNext.rdata = {24'h0, stateReg.lastEntry.desc};
                `EQ_REG_COUNT:    stateNext.rdata = 32'(stateReg.count);
                `EQ_REG_ESR:      stateNext.rdata = {24'h0, stateReg.esr};
                `EQ_REG_IRQ_STAT: stateNext.rdata = 32'(stateReg.irqStat);
                `EQ_REG_IRQ_MASK: stateNext.rdata = 32'(stateReg.irqMask);
                `EQ_REG_PANEL:    stateNext.rdata = {31'h0, stateReg.panelInd};
                default:          stateNext.rdata = '0;
            endcase
        end
        stateNext.irq = |(stateNext.irqStat & stateNext.irqMask);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign regRdata       = stateReg.rdata;
    assign panelErrValid  = stateReg.panelValid;
    assign panelErr       = stateReg.panelErr;
    assign panelIndicator = stateReg.panelInd;
    assign irq            = stateReg.irq;
endmodule
`default_nettype wire

// >>> dv/eq_chk.sv
// Concurrent checks on the error queue ports
`default_nettype none
`include "err_queue_cfg.svh"
module eq_chk #(
    parameter int DEPTH     = 30,
    parameter int PERSIST_W = 4
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 errValid,
    input wire logic                 outputQueueEmptyRead,
    input wire logic                 outputQueueLost,
    input wire logic                 paramOutOfRange,
    input wire logic                 execStateConflict,
    input wire logic                 headerUnknown,
    input wire logic [PERSIST_W-1:0] persistCond,
    input wire logic [3:0]           regAddr,
    input wire logic                 regWr,
    input wire logic                 regRd,
    input wire logic [31:0]          regRdata,
    input wire logic                 panelErrValid,
    input wire logic                 panelIndicator,
    input wire logic                 irq
);
    logic [5:0] cnt_reg;
    logic       stale_reg;
    wire logic  anyEvt = errValid | outputQueueEmptyRead | outputQueueLost
                       | paramOutOfRange | execStateConflict | headerUnknown;
    // Persistent sources re-queue on their own, so shadow count is void once seen
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg <= 6'h00;
            stale_reg <= 1'b0;
        end else begin
            if (|persistCond) stale_reg <= 1'b1;
            if (regWr && regAddr == `EQ_REG_CLEAR) cnt_reg <= 6'h00;
            else cnt_reg <= cnt_reg + 6'((anyEvt && cnt_reg < DEPTH) ? 1 : 0)
                - 6'((regRd && regAddr == `EQ_REG_POP && cnt_reg != 6'h00) ? 1 : 0);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_popRd;
        regRd && regAddr == `EQ_REG_POP;
    endsequence
    sequence s_clsWr;
        regWr && regAddr == `EQ_REG_CLEAR;
    endsequence
    a_empty_zero: assert property (s_popRd ##0 (cnt_reg == 6'h00 && !stale_reg)
        |=> regRdata[15:0] == 16'h0000) else $error("empty read code not zero");
    a_count_max: assert property (regRd && regAddr == `EQ_REG_COUNT
        |=> regRdata <= DEPTH) else $error("count above depth");
    a_cls_empty: assert property (s_clsWr ##1 !anyEvt ##1 (regRd && regAddr == `EQ_REG_COUNT)
        ##0 (!stale_reg && !anyEvt) |=> regRdata == 32'h0) else $error("clear left entries");
    a_panel_post: assert property (errValid |-> ##[1:2] panelErrValid)
        else $error("error not posted to panel");
    a_ind_set: assert property (errValid |-> ##[1:3] panelIndicator)
        else $error("panel indicator not set");
    a_ind_cls: assert property (s_clsWr ##0 (persistCond == '0 && !anyEvt)
        |-> ##[1:2] !panelIndicator) else $error("clear kept indicator");
    a_ind_pop: assert property (s_popRd ##0 (cnt_reg == 6'h01 && !stale_reg && !anyEvt)
        |-> ##[1:2] !panelIndicator) else $error("last read kept indicator");
    a_irq_reset: assert property ($fell(rst) |-> !irq)
        else $error("interrupt high after reset");
endmodule
`default_nettype wire

// >>> dv/host_model.sv
// Host side model: drives the register port and captures read replies
`default_nettype none
module host_model (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire err_queue_pkg::reg_req_t  req,
    output logic [3:0]                    regAddr,
    output logic [31:0]                   regWdata,
    output logic                          regWr,
    output logic                          regRd,
    input  wire logic [31:0]              regRdata,
    output logic [31:0]                   rdCapture
);
    logic rdPending_reg;
    assign regAddr = req.addr;
    assign regWdata = req.wdata;
    assign regWr = req.wr;
    assign regRd = req.rd;
    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdPending_reg <= 1'b0;
            rdCapture <= 32'h0;
        end else begin
            rdPending_reg <= req.rd;
            if (rdPending_reg) rdCapture <= regRdata;
        end
    end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the error queue
`default_nettype none
`include "err_queue_cfg.svh"
`define CHK(nm, e, g) n_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("Error %s exp %0d got %0d", nm, e, g); \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst, errValid, irq, panelErrValid, panelIndicator;
    logic signed [15:0] errCode;
    logic [7:0] errDesc;
    logic [3:0] persistCond, regAddr;
    logic [63:0] persistCode;
    logic [4:0] evt;
    logic [31:0] regWdata, regRdata, rdCapture, v, seed;
    logic regWr, regRd;
    err_queue_pkg::reg_req_t req;
    err_queue_pkg::err_entry_t panelErr;
    int q[$];
    int err_total, n_checks, cyc, ev;
    int codes[7] = '{-450, -320, 250, 805, -250, -150, -101};
    int cbit[7] = '{2, 3, 3, 3, 4, 5, 5};
    int ebit[5] = '{2, 2, 4, 4, 5};
    error_queue_event_status u_dut (.clk_sys(clk_sys), .rst(rst), .errValid(errValid),
        .errCode(errCode), .errDesc(errDesc), .persistCond(persistCond),
        .persistCode(persistCode), .outputQueueEmptyRead(evt[0]),
        .outputQueueLost(evt[1]), .paramOutOfRange(evt[2]), .execStateConflict(evt[3]),
        .headerUnknown(evt[4]), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .panelErrValid(panelErrValid),
        .panelErr(panelErr), .panelIndicator(panelIndicator), .irq(irq));
    host_model u_host (.clk_sys(clk_sys), .rst(rst), .req(req), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rdCapture(rdCapture));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        $display("Checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        req <= '0;
        if (a == `EQ_REG_CLEAR) q.delete();
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
        #1 d = rdCapture;
    endtask
    // Full queue keeps its oldest entries; the newest slot becomes overflow
    task automatic push(input int c);
        @(posedge clk_sys);
        errValid <= 1'b1;
        errCode <= 16'(c);
        errDesc <= 8'($random(seed));
        @(posedge clk_sys);
        errValid <= 1'b0;
        #1;
        `CHK("panelCode", 16'(c), panelErr.code)
        repeat (2) @(posedge clk_sys);
        if (q.size() < `EQ_DEPTH) q.push_back(c);
        else q[`EQ_DEPTH-1] = -350;
    endtask
    initial begin
        seed = 32'hD74EC5B0;
        {errValid, errCode, errDesc, persistCond, persistCode, evt} = '0;
        req = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`EQ_REG_COUNT, v);
        `CHK("count", 32'h0, v)
        rd(`EQ_REG_POP, v);
        `CHK("emptyCode", 16'h0000, v[15:0])
        rd(`EQ_REG_COUNT, v);
        `CHK("countKeep", 32'h0, v)
        foreach (codes[i]) begin
            push(codes[i]);
            rd(`EQ_REG_ESR, v);
            `CHK("esrClass", 4'(1 << (cbit[i] - 2)), v[5:2])
            wr(`EQ_REG_CLEAR, 32'h1);
            rd(`EQ_REG_COUNT, v);
            `CHK("clearCount", 32'h0, v)
        end
        for (ev = 0; ev < 5; ev++) begin
            @(posedge clk_sys);
            evt <= 5'(1 << ev);
            @(posedge clk_sys);
            evt <= 5'h00;
            repeat (2) @(posedge clk_sys);
            rd(`EQ_REG_ESR, v);
            `CHK("esrEvent", 4'(1 << (ebit[ev] - 2)), v[5:2])
            wr(`EQ_REG_CLEAR, 32'h1);
        end
        wr(`EQ_REG_IRQ_STAT, 32'h3);
        for (int i = 0; i <= `EQ_DEPTH; i++) push(-100 - int'(($random(seed) & 32'hFF) % 100));
        rd(`EQ_REG_COUNT, v);
        `CHK("fullCount", 32'(`EQ_DEPTH), v)
        rd(`EQ_REG_IRQ_STAT, v);
        `CHK("irqStat", 2'b11, v[1:0])
        while (q.size() > 0) begin
            rd(`EQ_REG_POP, v);
            `CHK("popCode", 16'(q.pop_front()), v[15:0])
        end
        rd(`EQ_REG_COUNT, v);
        `CHK("drained", 32'h0, v)
        wr(`EQ_REG_IRQ_STAT, 32'h3);
        wr(`EQ_REG_IRQ_MASK, 32'h1);
        push(-222);
        `CHK("irqUp", 1'b1, irq)
        wr(`EQ_REG_IRQ_STAT, 32'h1);
        #1;
        `CHK("irqDown", 1'b0, irq)
        wr(`EQ_REG_IRQ_MASK, 32'h0);
        push(-223);
        `CHK("irqMasked", 1'b0, irq)
        persistCode[15:0] <= 16'hFECA;
        persistCond <= 4'h1;
        wr(`EQ_REG_CLEAR, 32'h1);
        repeat (4) @(posedge clk_sys);
        rd(`EQ_REG_POP, v);
        `CHK("persist", 16'hFECA, v[15:0])
        persistCond <= 4'h0;
        complete_run();
    end
endmodule
bind error_queue_event_status eq_chk #(.DEPTH(DEPTH), .PERSIST_W(PERSIST_W)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .errValid(errValid),
    .outputQueueEmptyRead(outputQueueEmptyRead), .outputQueueLost(outputQueueLost),
    .paramOutOfRange(paramOutOfRange), .execStateConflict(execStateConflict),
    .headerUnknown(headerUnknown), .persistCond(persistCond), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .panelErrValid(panelErrValid),
    .panelIndicator(panelIndicator), .irq(irq));
`default_nettype wire
